// >>> tsdb_pkg.sv
// Purpose: Constants for the tape sense data builder
// Assumes: 36-byte fixed-format sense block, 32-bit Avalon-MM register bus
// Notes:   Offsets are byte addresses of word registers
// ==========================================================================
// Package
package tsdb_pkg;
  // ========================================================================
  // Sense byte codes and positions
  localparam logic [7:0] CODE_CURRENT  = 8'h70;
  localparam logic [7:0] CODE_DEFERRED = 8'h71;
  localparam logic [7:0] ADDR_MAX      = 8'h0f;
  localparam int         SENSE_LEN     = 36;
  localparam int         B_CODE        = 0;
  localparam int         B_SEGMENT     = 1;
  localparam int         B_FLAGS       = 2;
  localparam int         B_INFO        = 3;
  localparam int         B_SUSPECT     = 14;
  localparam int         B_CART        = 21;
  localparam int         B_LABEL       = 22;
  localparam int         B_WRAP        = 29;
  localparam int         B_LONGITUDINAL_POSITION        = 30;
  localparam int         B_ADDR        = 34;
  localparam int         FILEMARK_BIT  = 7;
  localparam int         EOM_BIT       = 6;
  localparam int         ILI_BIT       = 5;
  localparam int         CLEAN_BIT     = 3;
  localparam int         VOLV_BIT      = 0;
  localparam int         VALID_BIT     = 7;
  // ========================================================================
  // Register offsets (byte addresses)
  localparam logic [7:0] OFF_EVENT   = 8'h00; // R/W: event bits, held until rewritten; writing bit 8 starts a build
  localparam logic [7:0] OFF_INFO    = 8'h04; // Information value
  localparam logic [7:0] OFF_SUSPECT = 8'h08; // Suspect unit code
  localparam logic [7:0] OFF_STATUS  = 8'h0c; // Drive status bits
  localparam logic [7:0] OFF_LABEL_L = 8'h10; // Label bytes 0..3
  localparam logic [7:0] OFF_LABEL_H = 8'h14; // Label bytes 4..6
  localparam logic [7:0] OFF_LONGITUDINAL_POSITION    = 8'h18; // Longitudinal position
  localparam logic [7:0] OFF_IRQ_ST  = 8'h1c; // Sticky status, read clears
  localparam logic [7:0] OFF_IRQ_MSK = 8'h20; // Interrupt mask
  localparam logic [7:0] OFF_SENSE   = 8'h40; // Sense bytes, 9 words 0x40..0x60
  // ========================================================================
  // Event register field positions
  localparam int EV_DEFERRED = 0;  // Error is deferred
  localparam int EV_FILEMARK = 1;  // Space/read/verify stopped on file mark
  localparam int EV_EW_WRITE = 2;  // Write finished in early warning
  localparam int EV_PAST_EOD = 3;  // Read/space past end of recorded data
  localparam int EV_INTO_BOM = 4;  // Space into beginning of medium
  localparam int EV_LEN_MISM = 5;  // Block length mismatch
  localparam int EV_BUILD    = 8;  // Build sense block now
  // Status register field positions
  localparam int ST_CLEAN  = 0;
  localparam int ST_LOADED = 1;
  localparam int ST_LABELV = 2;
  localparam int ST_WRAP   = 8;    // 8 bits
  localparam int ST_ADDR   = 16;   // 4 bits
  // Interrupt bits
  localparam int IRQ_BUILT = 0;
  localparam int IRQ_CLEAN = 1;
  localparam logic [1:0] IRQ_RESET = 2'h0;
  // Builder states
  typedef enum logic [1:0] {
    TSDB_IDLE  = 2'b00,
    TSDB_BUILD = 2'b01,
    TSDB_DONE  = 2'b11
  } tsdb_state_e;
endpackage : tsdb_pkg

// >>> tsdb_top.sv
// Purpose: Builds the fixed-format tape sense block read by an initiator
// Assumes: Firmware posts command outcome over Avalon-MM, then reads sense words
// Notes:   Sense bytes stay frozen between builds so a request-sense returns them
// ==========================================================================
// Functional notes
// [RULE1] Byte 0 is 70h for a current error, 71h for a deferred one.
// [RULE2] Segment byte 1 is always zero.
// [RULE3] Byte 2 bit 7 set when space/read/verify stopped on a file mark.
// [RULE4] Byte 2 bit 6 set when a write ended in the early warning area.
// [RULE5] Bit 6 also set on passing end of data or spacing into medium start.
// [RULE6] Byte 2 bit 5 set when a read/verify block length mismatched.
// [RULE7] Information bytes 3-5 flagged valid only for current errors.
// [RULE8] Byte 14 holds zero or a vendor suspect unit code.
// [RULE9] Byte 21 bit 3 follows the need-cleaning state.
// [RULE10] Byte 21 bit 0 set only when the label contents are valid.
// [RULE11] Bytes 22-28 carry the label when loaded and label valid.
// [RULE12] Byte 29 is the wrap; its LSB gives the direction.
// [RULE13] Bytes 30-33 carry the longitudinal position.
// [RULE14] Byte 34 carries the bus address, always 00h to 0Fh.
// [RULE15] A request-sense read returns the block built for the last condition.
module tsdb_top (
  input  wire logic        clk_sys,
  input  wire logic        rst,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  output logic             irq
);
  // ========================================================================
  // Bus handshake: one wait cycle, answer on the second edge
  logic        ack_reg;
  logic        access;
  assign access = (avs_read | avs_write) & ~ack_reg;

  always_ff @(posedge clk_sys) begin
    if (rst) ack_reg <= 1'b0;
    else     ack_reg <= access;
  end
  // Wait flag straight from a flop; idle and reset both hold it high
  always_ff @(posedge clk_sys) begin
    if (rst) avs_waitrequest <= 1'b1;
    else     avs_waitrequest <= ~access;
  end
  logic wr_go;
  logic rd_go;
  assign wr_go = avs_write & ack_reg;
  assign rd_go = avs_read & ack_reg;

  // ========================================================================
  // Software-written configuration registers
  logic [31:0] event_reg;
  logic [23:0] info_reg;
  logic [7:0]  suspect_reg;
  logic [31:0] status_reg;
  logic [55:0] label_reg;
  logic [31:0] longitudinal_position_reg;
  logic [1:0]  irq_mask_reg;
  logic        build_req;
  assign build_req = wr_go && avs_address == tsdb_pkg::OFF_EVENT
                     && avs_writedata[tsdb_pkg::EV_BUILD];

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) r[8*i +: 8] = nw[8*i +: 8];
    end
    return r;
  endfunction : merge

  // Register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      event_reg    <= 32'h0000_0000;
      info_reg     <= 24'h00_0000;
      suspect_reg  <= 8'h00;
      status_reg   <= 32'h0000_0000;
      label_reg    <= 56'h00_0000_0000_0000;
      longitudinal_position_reg     <= 32'h0000_0000;
      irq_mask_reg <= 2'h0;
    end else if (wr_go) begin
      unique case (avs_address)
        tsdb_pkg::OFF_EVENT:   event_reg   <= merge(event_reg, avs_writedata, avs_byteenable);
        tsdb_pkg::OFF_INFO:    info_reg    <= 24'(merge({8'h00, info_reg}, avs_writedata,
                                                        avs_byteenable));
        tsdb_pkg::OFF_SUSPECT: suspect_reg <= avs_byteenable[0] ? avs_writedata[7:0]
                                                                : suspect_reg;
        tsdb_pkg::OFF_STATUS:  status_reg  <= merge(status_reg, avs_writedata, avs_byteenable);
        tsdb_pkg::OFF_LABEL_L: label_reg[31:0] <= merge(label_reg[31:0], avs_writedata,
                                                        avs_byteenable);
        tsdb_pkg::OFF_LABEL_H: label_reg[55:32] <= 24'(merge({8'h00, label_reg[55:32]},
                                                             avs_writedata, avs_byteenable));
        tsdb_pkg::OFF_LONGITUDINAL_POSITION:    longitudinal_position_reg    <= merge(longitudinal_position_reg, avs_writedata, avs_byteenable);
        tsdb_pkg::OFF_IRQ_MSK: irq_mask_reg <= avs_byteenable[0] ? avs_writedata[1:0]
                                                                 : irq_mask_reg;
        default: ;
      endcase
    end
  end

  // ========================================================================
  // Builder state machine: idle -> build (one cycle) -> done
  tsdb_pkg::tsdb_state_e state_reg;
  tsdb_pkg::tsdb_state_e state_next;
  always_comb begin
    state_next = state_reg;
    unique case (state_reg)
      tsdb_pkg::TSDB_IDLE:  if (build_req) state_next = tsdb_pkg::TSDB_BUILD;
      tsdb_pkg::TSDB_BUILD: state_next = tsdb_pkg::TSDB_DONE;
      tsdb_pkg::TSDB_DONE:  if (build_req) state_next = tsdb_pkg::TSDB_BUILD;
      default:              state_next = tsdb_pkg::TSDB_IDLE;
    endcase
  end
  always_ff @(posedge clk_sys) begin
    if (rst) state_reg <= tsdb_pkg::TSDB_IDLE;
    else     state_reg <= state_next;
  end

  // ========================================================================
  // Sense block assembly; frozen after the build so reads stay consistent
  logic [7:0] sense_reg [tsdb_pkg::SENSE_LEN];
  logic [7:0] sense_next [tsdb_pkg::SENSE_LEN];
  logic       deferred;
  logic       label_ok;
  assign deferred = event_reg[tsdb_pkg::EV_DEFERRED];
  assign label_ok = status_reg[tsdb_pkg::ST_LOADED] & status_reg[tsdb_pkg::ST_LABELV];

  always_comb begin
    for (int i = 0; i < tsdb_pkg::SENSE_LEN; i++) sense_next[i] = 8'h00;
    sense_next[tsdb_pkg::B_CODE] = deferred ? tsdb_pkg::CODE_DEFERRED
                                            : tsdb_pkg::CODE_CURRENT; // RULE1
    sense_next[tsdb_pkg::B_CODE][tsdb_pkg::VALID_BIT] = ~deferred; // RULE7
    sense_next[tsdb_pkg::B_SEGMENT] = 8'h00; // RULE2
    sense_next[tsdb_pkg::B_FLAGS][tsdb_pkg::FILEMARK_BIT] =
      event_reg[tsdb_pkg::EV_FILEMARK]; // RULE3
    sense_next[tsdb_pkg::B_FLAGS][tsdb_pkg::EOM_BIT] =
      event_reg[tsdb_pkg::EV_EW_WRITE] // RULE4
      | event_reg[tsdb_pkg::EV_PAST_EOD] | event_reg[tsdb_pkg::EV_INTO_BOM]; // RULE5
    sense_next[tsdb_pkg::B_FLAGS][tsdb_pkg::ILI_BIT] = event_reg[tsdb_pkg::EV_LEN_MISM]; // RULE6
    // Information bytes are zeroed for deferred errors, valid bit clear
    for (int i = 0; i < 3; i++) begin
      sense_next[tsdb_pkg::B_INFO + i] = deferred ? 8'h00 : info_reg[8*(2-i) +: 8]; // RULE7
    end
    sense_next[tsdb_pkg::B_SUSPECT] = suspect_reg; // RULE8
    sense_next[tsdb_pkg::B_CART][tsdb_pkg::CLEAN_BIT] = status_reg[tsdb_pkg::ST_CLEAN]; // RULE9
    sense_next[tsdb_pkg::B_CART][tsdb_pkg::VOLV_BIT] = label_ok; // RULE10
    for (int i = 0; i < 7; i++) begin
      sense_next[tsdb_pkg::B_LABEL + i] = label_ok ? label_reg[8*i +: 8] : 8'h00; // RULE11
    end
    sense_next[tsdb_pkg::B_WRAP] = status_reg[tsdb_pkg::ST_WRAP +: 8]; // RULE12
    for (int i = 0; i < 4; i++) begin
      sense_next[tsdb_pkg::B_LONGITUDINAL_POSITION + i] = longitudinal_position_reg[8*(3-i) +: 8]; // RULE13
    end
    // Only four address bits exist, so the value never passes 0Fh
    sense_next[tsdb_pkg::B_ADDR] = {4'h0, status_reg[tsdb_pkg::ST_ADDR +: 4]}; // RULE14
  end

  // Capture on build only
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      for (int i = 0; i < tsdb_pkg::SENSE_LEN; i++) sense_reg[i] <= 8'h00;
    end else if (state_reg == tsdb_pkg::TSDB_BUILD) begin
      for (int i = 0; i < tsdb_pkg::SENSE_LEN; i++) sense_reg[i] <= sense_next[i]; // RULE15
    end
  end

  // ========================================================================
  // Interrupts: sticky, read of status clears, set wins over clear
  logic [1:0] irq_st_reg;
  logic       clean_d_reg;
  logic [1:0] irq_set;
  logic [1:0] irq_st_next;
  logic       st_rd;
  assign st_rd = rd_go && avs_address == tsdb_pkg::OFF_IRQ_ST;
  assign irq_set[tsdb_pkg::IRQ_BUILT] = state_reg == tsdb_pkg::TSDB_BUILD;
  assign irq_set[tsdb_pkg::IRQ_CLEAN] = status_reg[tsdb_pkg::ST_CLEAN] & ~clean_d_reg;
  // Clear only the bits the read reported, so a set landing mid-read survives
  assign irq_st_next = (st_rd ? irq_st_reg & ~avs_readdata[1:0] : irq_st_reg) | irq_set;
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      irq_st_reg  <= tsdb_pkg::IRQ_RESET;
      clean_d_reg <= 1'b0;
      irq         <= 1'b0;
    end else begin
      irq_st_reg  <= irq_st_next;
      clean_d_reg <= status_reg[tsdb_pkg::ST_CLEAN];
      irq         <= |(irq_st_next & irq_mask_reg);
    end
  end

  // ========================================================================
  // Read data, registered at the first edge, the one that drops waitrequest
  logic [31:0] rd_mux;
  logic [5:0]  widx;
  // Six index bits so addresses above the sense window cannot alias into it
  assign widx = 6'((avs_address - tsdb_pkg::OFF_SENSE) >> 2);
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (avs_address >= tsdb_pkg::OFF_SENSE && widx < 6'h09) begin
      // Sense byte 4n in the low lane
      for (int b = 0; b < 4; b++) rd_mux[8*b +: 8] = sense_reg[int'(widx) * 4 + b];
    end else begin
      unique case (avs_address)
        tsdb_pkg::OFF_EVENT:   rd_mux = event_reg;
        tsdb_pkg::OFF_INFO:    rd_mux = {8'h00, info_reg};
        tsdb_pkg::OFF_SUSPECT: rd_mux = {24'h00_0000, suspect_reg};
        tsdb_pkg::OFF_STATUS:  rd_mux = status_reg;
        tsdb_pkg::OFF_LABEL_L: rd_mux = label_reg[31:0];
        tsdb_pkg::OFF_LABEL_H: rd_mux = {8'h00, label_reg[55:32]};
        tsdb_pkg::OFF_LONGITUDINAL_POSITION:    rd_mux = longitudinal_position_reg;
        tsdb_pkg::OFF_IRQ_ST:  rd_mux = {30'h0, irq_st_reg};
        tsdb_pkg::OFF_IRQ_MSK: rd_mux = {30'h0, irq_mask_reg};
        default:               rd_mux = 32'h0000_0000;
      endcase
    end
  end
  // Data is valid while waitrequest is low
  always_ff @(posedge clk_sys) begin
    if (rst)         avs_readdata <= 32'h0000_0000;
    else if (access) avs_readdata <= rd_mux;
  end

  // ========================================================================
  // Checks
  chk_code_select: assert property (@(posedge clk_sys) disable iff (rst) // RULE1
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[0][6:0] ==
      ($past(deferred) ? 7'h71 : 7'h70)) else $error("bad error code");
  chk_segment_zero: assert property (@(posedge clk_sys) disable iff (rst) // RULE2
    sense_reg[tsdb_pkg::B_SEGMENT] == 8'h00) else $error("segment nonzero");
  chk_filemark_flag: assert property (@(posedge clk_sys) disable iff (rst) // RULE3
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[2][7] == $past(event_reg[1]))
    else $error("file mark flag wrong");
  chk_eom_flag: assert property (@(posedge clk_sys) disable iff (rst) // RULE4
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[2][6] == $past(|event_reg[4:2]))
    else $error("end of media flag wrong");
  chk_eom_eod: assert property (@(posedge clk_sys) disable iff (rst) // RULE5
    state_reg == tsdb_pkg::TSDB_BUILD && event_reg[3] |=> sense_reg[2][6])
    else $error("past data not flagged");
  chk_len_flag: assert property (@(posedge clk_sys) disable iff (rst) // RULE6
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[2][5] == $past(event_reg[5]))
    else $error("length flag wrong");
  chk_valid_current: assert property (@(posedge clk_sys) disable iff (rst) // RULE7
    sense_reg[0][7] |-> sense_reg[0][6:0] == 7'h70) else $error("valid on deferred");
  chk_suspect_copy: assert property (@(posedge clk_sys) disable iff (rst) // RULE8
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[14] == $past(suspect_reg))
    else $error("suspect code wrong");
  chk_clean_follow: assert property (@(posedge clk_sys) disable iff (rst) // RULE9
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[21][3] == $past(status_reg[0]))
    else $error("clean flag wrong");
  chk_label_gate: assert property (@(posedge clk_sys) disable iff (rst) // RULE10
    !sense_reg[21][0] |-> sense_reg[22] == 8'h00) else $error("label without valid");
  // Top label byte checked so a short copy loop would be caught
  chk_label_copy: assert property (@(posedge clk_sys) disable iff (rst) // RULE11
    state_reg == tsdb_pkg::TSDB_BUILD && label_ok |=> sense_reg[28] == $past(label_reg[55:48]))
    else $error("label byte wrong");
  chk_wrap_copy: assert property (@(posedge clk_sys) disable iff (rst) // RULE12
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[29] == $past(status_reg[15:8]))
    else $error("wrap byte wrong");
  chk_longitudinal_position_order: assert property (@(posedge clk_sys) disable iff (rst) // RULE13
    state_reg == tsdb_pkg::TSDB_BUILD |=> sense_reg[30] == $past(longitudinal_position_reg[31:24]))
    else $error("position byte order wrong");
  chk_addr_range: assert property (@(posedge clk_sys) disable iff (rst) // RULE14
    sense_reg[tsdb_pkg::B_ADDR] <= tsdb_pkg::ADDR_MAX) else $error("address out of range");
  // Block must not drift between builds, or a late fetch sees a mixed block
  chk_sense_frozen: assert property (@(posedge clk_sys) disable iff (rst) // RULE15
    state_reg != tsdb_pkg::TSDB_BUILD |=> $stable(sense_reg[2]) && $stable(sense_reg[34]))
    else $error("sense changed without build");
  chk_bus_answer: assert property (@(posedge clk_sys) disable iff (rst)
    avs_read && avs_waitrequest |=> !avs_waitrequest) else $error("late answer");
  chk_write_answer: assert property (@(posedge clk_sys) disable iff (rst)
    avs_write && avs_waitrequest |=> !avs_waitrequest) else $error("late write answer");
  cov_deferred: cover property (@(posedge clk_sys) sense_reg[0] == 8'h71);
  cov_eom: cover property (@(posedge clk_sys) sense_reg[2][6]);
  cov_irq: cover property (@(posedge clk_sys) irq);
  cov_label_valid: cover property (@(posedge clk_sys) sense_reg[21][0]);
  cov_read_clear: cover property (@(posedge clk_sys) st_rd && irq_st_reg != 2'h0);
endmodule : tsdb_top

// >>> tsdb_initiator_model.sv
// Purpose: Initiator that fetches the sense block word by word
// Assumes: Owns the register bus only while the bench selects it
// Notes:   Gap input stretches the pause between reads to act slowly
// ==========================================================================
// Initiator model
module tsdb_initiator_model (
  input  wire logic         clk_sys,
  input  wire logic         start,
  input  wire logic [3:0]   gap,
  input  wire logic [31:0]  avs_readdata,
  input  wire logic         avs_waitrequest,
  output logic      [7:0]   avs_address,
  output logic              avs_read,
  output logic              done,
  output logic      [287:0] sense_bytes
);
  timeunit 1ns;
  timeprecision 1ns;
  // Request-sense fetch: nine word reads, held until waitrequest drops
  initial begin
    avs_address = 8'h00;
    avs_read    = 1'b0;
    done        = 1'b0;
    sense_bytes = '0;
    forever begin
      @(posedge clk_sys);
      if (start === 1'b1) begin
        for (int n = 0; n < 9; n++) begin
          avs_address <= tsdb_pkg::OFF_SENSE + 8'(4 * n);
          avs_read    <= 1'b1;
          do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
          sense_bytes[n*32 +: 32] <= avs_readdata;
          avs_read    <= 1'b0;
          avs_address <= ~avs_address; // Stale address would hide decode faults
          repeat (gap + 1) @(posedge clk_sys);
        end
        done <= 1'b1;
        @(posedge clk_sys);
        done <= 1'b0;
      end
    end
  end
endmodule : tsdb_initiator_model

// >>> testbench.sv
// Purpose: Self-checking bench for the tape sense data builder
// Assumes: Firmware side driven here, initiator side by the partner model
// Notes:   Build result is fetched once the event write ends and three more cycles pass
// ==========================================================================
// Bench top
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic        clk_sys, rst, sel, p_start, p_read, p_done, tb_read, tb_write, irq;
  logic [7:0]  p_addr, tb_addr, avs_address;
  logic [31:0] tb_wdata, avs_readdata, rd, info_v, susp_v, st_v, ll_v, lh_v, longitudinal_position_v;
  logic        avs_waitrequest;
  logic [3:0]  p_gap, tb_be;
  logic [287:0] sense;
  int          error_cnt, compares, cyc;
  // Bus ownership: partner while fetching, bench otherwise
  assign avs_address = sel ? p_addr : tb_addr;
  tsdb_top dut (.clk_sys(clk_sys), .rst(rst), .avs_address(avs_address),
    .avs_read(sel ? p_read : tb_read), .avs_write(sel ? 1'b0 : tb_write),
    .avs_writedata(tb_wdata), .avs_byteenable(tb_be), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .irq(irq));
  tsdb_initiator_model partner (.clk_sys(clk_sys), .start(p_start), .gap(p_gap),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
    .avs_address(p_addr), .avs_read(p_read), .done(p_done), .sense_bytes(sense));
  initial begin
    clk_sys = 1'b0;
    forever #50 clk_sys = ~clk_sys;
  end
  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      print_verdict();
    end
  end
  // ========================================================================
  // Shared tasks
  task automatic check(input string name, input logic [63:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic bus_write(input logic [7:0] a, input logic [31:0] d);
    tb_addr <= a;
    tb_wdata <= d;
    tb_write <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    tb_write <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_write
  task automatic bus_read(input logic [7:0] a, output logic [31:0] d);
    tb_addr <= a;
    tb_read <= 1'b1;
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    d = avs_readdata;
    tb_read <= 1'b0;
    @(posedge clk_sys);
  endtask : bus_read
  function automatic logic [7:0] sb(input int k);
    return sense[k*8 +: 8];
  endfunction : sb
  // Post drive state and an event, build, fetch, and judge the block
  task automatic build_and_check(input logic [31:0] ev, input logic [3:0] gap);
    logic d, lv;
    d  = ev[tsdb_pkg::EV_DEFERRED];
    lv = st_v[tsdb_pkg::ST_LOADED] & st_v[tsdb_pkg::ST_LABELV];
    bus_write(tsdb_pkg::OFF_INFO, info_v);
    bus_write(tsdb_pkg::OFF_SUSPECT, susp_v);
    bus_write(tsdb_pkg::OFF_STATUS, st_v);
    bus_write(tsdb_pkg::OFF_LABEL_L, ll_v);
    bus_write(tsdb_pkg::OFF_LABEL_H, lh_v);
    bus_write(tsdb_pkg::OFF_LONGITUDINAL_POSITION, longitudinal_position_v);
    bus_write(tsdb_pkg::OFF_EVENT, ev | (32'h1 << tsdb_pkg::EV_BUILD));
    repeat (3) @(posedge clk_sys);
    p_gap <= gap;
    sel <= 1'b1;
    p_start <= 1'b1;
    @(posedge clk_sys);
    p_start <= 1'b0;
    do @(posedge clk_sys); while (p_done !== 1'b1);
    sel <= 1'b0;
    check("code", sb(0), d ? 8'h71 : 8'hf0);
    check("segment", sb(1), 8'h00);
    check("flags", sb(2) & 8'he0, {ev[1], |ev[4:2], ev[5], 5'h00});
    check("info", {sb(3), sb(4), sb(5)}, d ? 24'h0 : info_v[23:0]);
    check("suspect", sb(14), susp_v[7:0]);
    check("cart", sb(21) & 8'h09, {4'h0, st_v[0], 2'h0, lv});
    check("label", sense[22*8 +: 56], lv ? {lh_v[23:0], ll_v} : 56'h0);
    check("wrap", sb(29), st_v[15:8]);
    check("longitudinal_position", {sb(30), sb(31), sb(32), sb(33)}, longitudinal_position_v);
    check("bus_addr", sb(34), {4'h0, st_v[19:16]});
  endtask : build_and_check
  // ========================================================================
  // Scenarios
  task automatic test_regs();
    bus_read(tsdb_pkg::OFF_IRQ_ST, rd);
    check("irq_st_rst", rd, {30'h0, tsdb_pkg::IRQ_RESET});
    bus_read(tsdb_pkg::OFF_IRQ_MSK, rd);
    check("mask_rst", rd, 32'h0);
    bus_write(8'h30, 32'hffffffff);
    bus_read(8'h30, rd);
    check("unmapped", rd, 32'h0);
    // Single-lane write must leave the other three lanes untouched
    bus_write(tsdb_pkg::OFF_LONGITUDINAL_POSITION, 32'h11223344);
    tb_be <= 4'h1;
    bus_write(tsdb_pkg::OFF_LONGITUDINAL_POSITION, 32'hffffffaa);
    tb_be <= 4'hf;
    bus_read(tsdb_pkg::OFF_LONGITUDINAL_POSITION, rd);
    check("lane_merge", rd, 32'h112233aa);
    $display("test_regs done");
  endtask : test_regs
  task automatic test_current();
    info_v = 32'h00123456;
    susp_v = 32'h5a;
    st_v = 32'h000f1307;
    ll_v = 32'h44434241;
    lh_v = 32'h00474645;
    longitudinal_position_v = 32'h89abcdef;
    build_and_check(32'h22, 4'h0);
    build_and_check(32'h00, 4'h2);
    // Above the sense window must read zero, not wrap onto word 0
    bus_read(8'h80, rd);
    check("sense_alias", rd, 32'h0);
    $display("test_current done");
  endtask : test_current
  task automatic test_deferred();
    logic [31:0] evs [3] = '{32'h05, 32'h09, 32'h11};
    st_v = 32'h00032404; // Label valid but no cartridge: label must read zero
    susp_v = 32'h0;
    foreach (evs[i]) build_and_check(evs[i], 4'h3);
    $display("test_deferred done");
  endtask : test_deferred
  task automatic test_irq();
    bus_read(tsdb_pkg::OFF_IRQ_ST, rd);
    bus_write(tsdb_pkg::OFF_IRQ_MSK, 32'h1);
    bus_write(tsdb_pkg::OFF_EVENT, 32'h100);
    repeat (4) @(posedge clk_sys);
    check("irq_built", irq, 1'b1);
    bus_read(tsdb_pkg::OFF_IRQ_ST, rd);
    check("irq_st", rd[1:0], 2'h1);
    repeat (2) @(posedge clk_sys);
    check("irq_clr", irq, 1'b0);
    bus_write(tsdb_pkg::OFF_STATUS, 32'h1);
    repeat (2) @(posedge clk_sys);
    check("irq_masked", irq, 1'b0);
    bus_write(tsdb_pkg::OFF_IRQ_MSK, 32'h2);
    repeat (2) @(posedge clk_sys);
    check("irq_clean", irq, 1'b1);
    bus_read(tsdb_pkg::OFF_IRQ_ST, rd);
    check("irq_st_clean", rd[1:0], 2'h2);
    repeat (2) @(posedge clk_sys);
    check("irq_clean_clr", irq, 1'b0);
    $display("test_irq done");
  endtask : test_irq
  task automatic print_verdict();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : print_verdict
  // Main sequence
  initial begin
    {rst, sel, p_start, tb_read, tb_write} = 5'b10000;
    {tb_addr, tb_wdata, p_gap, error_cnt, compares, cyc} = '0;
    tb_be = 4'hf;
    repeat (16) @(posedge clk_sys);
    check("wait_in_rst", avs_waitrequest, 1'b1);
    check("irq_in_rst", irq, 1'b0);
    rst <= 1'b0;
    @(posedge clk_sys);
    test_regs();
    test_current();
    test_deferred();
    test_irq();
    print_verdict();
  end
endmodule : testbench
